//--- card_end.sv
// Card end: information registers and select handling on the serial link
`timescale 1ns/10ps
// Operation
// - Host selects card per command, select low
// - Select held low for whole transaction
// - Select release during programming is harmless
// - No broadcast commands; only selected card answers (this card answers every command whether selected or not)
// - No new command during data transfer
// - Single-block transfers only, no multi-block
// - Voltage, identity, specific records readable; address not
// - Voltage register is 32-bit read-only
// - Voltage bit 31 shows power-up status
// - Voltage bits 23:15 one, others zero
// - 128-bit identity record, read-only
// - Identity fields fixed layout, bit zero one
// - Records returned only by their read commands
// - Address register 16 bits, write-only
// - Address register resets to one
// - Select with address zero means standby
// - Set-address command loads address register
// - Power-down resets address to one, records kept
// - 128-bit specific record, user part programmable
// - Link data whole bytes aligned to select
module card_end #(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
	parameter logic [15:0] APP_CODE = 16'h4242, // Arbitrary value
	parameter logic [47:0] PRODUCT_NAME = 48'h434152443031,
	parameter logic [7:0] REVISION = 8'h10,
	parameter logic [31:0] SERIAL = 32'h00000001,
	parameter logic [7:0] MFG_DATE = 8'h11,
	parameter logic [6:0] ID_CRC = 7'h00,
	parameter logic [127:0] SPEC_FIXED = '0,
	parameter int PROG_CYC = card_pkg::PROG_CYCLES,
	parameter int PWRUP_CYC = card_pkg::PWRUP_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Serial link
	spi_link_if.card link,
	// User side
	input wire logic power_down_i,
	output logic card_selected_o,
	output logic prog_busy_o,
	output logic power_ready_o
);
	import card_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Pin sampling and edge finding
	logic [2:0] pins_s; // {cs_n, sclk, mosi} after two flops
	logic sclk_d_r; // Previous synced clock level
	link_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({link.cs_n, link.sclk, link.mosi}),
		.q_o(pins_s)
	);
	wire cs_n_s = pins_s[2];
	wire sclk_s = pins_s[1];
	wire mosi_s = pins_s[0];
	wire rise = sclk_s & ~sclk_d_r & ~cs_n_s;
	wire fall = ~sclk_s & sclk_d_r & ~cs_n_s;

	// Clock history for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_d_r <= 1'b0;
		end else begin
			sclk_d_r <= sclk_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Storage
	card_state_t state_r; // Transaction phase
	logic [2:0] bit_r; // Bit within byte, counted from select
	logic [7:0] rx_r; // Incoming shift
	logic [7:0] tx_r; // Outgoing shift, msb on the pin
	logic [4:0] idx_r; // Byte index or bytes left
	logic [7:0] cmd_r; // Latched command code
	logic [15:0] arg_r; // Argument or program data
	logic [127:0] out_r; // Remaining read-out data
	logic [SPEC_USER_W-1:0] user_spec_r; // Programmable record part
	logic [15:0] addr_r; // Relative address, never sent out
	logic [15:0] prog_cnt_r; // Programming timer
	logic [15:0] pwr_cnt_r; // Power-up timer
	logic pwr_ready_r; // Power-up done
	logic selected_r; // Card addressed by select command

	////////////////////////////////////////////////////////////////////
	// Decode
	wire byte_done = rise & (bit_r == BIT_LAST);
	wire [7:0] rx_byte = {rx_r[6:0], mosi_s};
	wire [15:0] arg_full = {arg_r[7:0], rx_byte};
	wire is_volt = cmd_r == CMD_READ_VOLT;
	wire is_ident = cmd_r == CMD_READ_IDENT;
	wire is_spec = cmd_r == CMD_READ_SPEC;
	wire is_prog = cmd_r == CMD_PROG_SPEC;
	wire is_read = is_volt | is_ident | is_spec;
	// Unknown codes, broadcast and multi-block ones are refused
	wire legal = is_read | is_prog | (cmd_r == CMD_SET_ADDR) |
		(cmd_r == CMD_SELECT);
	wire cmd_end = byte_done & (state_r == CS_CMD) &
		(idx_r == CMD_BYTES - 5'h01);
	wire [7:0] resp_byte = (legal ? 8'h00 : RESP_ILLEGAL) |
		(pwr_ready_r ? 8'h00 : RESP_IDLE);
	// Voltage word: ready flag on top, fixed window below
	wire [31:0] volt_word = VOLT_WINDOW |
		(pwr_ready_r ? VOLT_READY : 32'h00000000);
	wire [127:0] id_word = {MAKER_CODE, APP_CODE, PRODUCT_NAME,
		REVISION, SERIAL, MFG_DATE, ID_CRC, 1'b1};
	wire [127:0] spec_word = {SPEC_FIXED[127:SPEC_USER_W+1],
		user_spec_r, 1'b1};
	// Left-aligned so bytes leave from the top
	wire [127:0] data_sel = is_volt ? {volt_word, 96'h0} :
		(is_ident ? id_word : spec_word);
	wire [4:0] data_len = is_volt ? VOLT_BYTES : REC_BYTES;
	wire prog_done = (state_r == CS_PROG) &
		(prog_cnt_r == 16'(PROG_CYC - 1));
	// Select release ends a frame, except while programming
	wire cs_idle = cs_n_s & (state_r != CS_PROG);

	// Next byte to put on the data-out line
	logic [7:0] tx_load;
	always_comb begin
		tx_load = FILL_BYTE;
		unique case (state_r)
			CS_CMD: tx_load = (idx_r == CMD_BYTES - 5'h01) ?
				resp_byte : FILL_BYTE;
			CS_RESP: tx_load = (legal & is_read) ?
				data_sel[127:120] : FILL_BYTE;
			CS_OUT: tx_load = (idx_r > 5'h01) ?
				out_r[127:120] : FILL_BYTE;
			CS_IN: tx_load = BUSY_BYTE;
			CS_PROG: tx_load = BUSY_BYTE;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Bit counter and receive shift, restarted by each select
	always_ff @(posedge clk_i) begin
		if (rst_i | cs_n_s) begin
			bit_r <= 3'h0;
			rx_r <= 8'h00;
		end else if (rise) begin
			bit_r <= bit_r + 3'h1;
			rx_r <= rx_byte;
		end
	end

	// Transmit shift: load at byte end, shift on falls inside a byte
	always_ff @(posedge clk_i) begin
		if (rst_i | cs_idle) begin
			tx_r <= FILL_BYTE;
		end else if (byte_done) begin
			tx_r <= tx_load;
		end else if (fall & (bit_r != 3'h0)) begin
			tx_r <= {tx_r[6:0], state_r != CS_PROG};
		end
	end
	assign link.miso = tx_r[7];

	////////////////////////////////////////////////////////////////////
	// Transaction sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i | cs_idle) begin
			state_r <= CS_CMD;
			idx_r <= 5'h00;
		end else if (prog_done) begin
			state_r <= CS_CMD;
			idx_r <= 5'h00;
		end else if (byte_done) begin
			unique case (state_r)
				// Collect code and two argument bytes
				CS_CMD: begin
					idx_r <= idx_r + 5'h01;
					if (cmd_end) begin
						state_r <= CS_RESP;
					end
				end
				// After the answer, only data of this command moves
				CS_RESP: begin
					idx_r <= legal & is_read ? data_len : PROG_BYTES;
					if (legal & is_read) begin
						state_r <= CS_OUT;
					end else if (legal & is_prog) begin
						state_r <= CS_IN;
					end else begin
						state_r <= CS_CMD;
						idx_r <= 5'h00;
					end
				end
				// One block only, then command phase after output, programming after input
				CS_OUT, CS_IN: begin
					idx_r <= idx_r - 5'h01;
					if (idx_r == 5'h01) begin
						state_r <= state_r == CS_IN ? CS_PROG : CS_CMD;
						idx_r <= 5'h00;
					end
				end
				// Input ignored until programming ends
				CS_PROG: idx_r <= 5'h00;
			endcase
		end
	end

	// Command, argument and read-out data capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_r <= 8'h00;
			arg_r <= 16'h0000;
			out_r <= '0;
		end else if (byte_done) begin
			if (state_r == CS_CMD && idx_r == 5'h00) begin
				cmd_r <= rx_byte;
			end
			if (state_r == CS_CMD || state_r == CS_IN) begin
				arg_r <= arg_full;
			end
			if (state_r == CS_RESP) begin
				out_r <= {data_sel[119:0], 8'h00};
			end else if (state_r == CS_OUT) begin
				out_r <= {out_r[119:0], 8'h00};
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Address register and selection; power-down acts like power-up
	always_ff @(posedge clk_i) begin
		if (rst_i | power_down_i) begin
			addr_r <= ADDR_RESET;
			selected_r <= 1'b0;
		end else if (cmd_end & (cmd_r == CMD_SET_ADDR)) begin
			addr_r <= arg_full;
		end else if (cmd_end & (cmd_r == CMD_SELECT)) begin
			// Zero puts the card in standby, never selects it
			selected_r <= (arg_full != ADDR_STANDBY) &
				(arg_full == addr_r);
		end
	end

	// Programming timer runs on regardless of select
	always_ff @(posedge clk_i) begin
		if (rst_i | (state_r != CS_PROG)) begin
			prog_cnt_r <= 16'h0000;
		end else begin
			prog_cnt_r <= prog_cnt_r + 16'h0001;
		end
	end

	// User record part survives power-down; only reset clears it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			user_spec_r <= '0;
		end else if (prog_done) begin
			user_spec_r <= arg_r[SPEC_USER_W:1];
		end
	end

	// Power-up timer drives the ready flag
	always_ff @(posedge clk_i) begin
		if (rst_i | power_down_i) begin
			pwr_cnt_r <= 16'h0000;
			pwr_ready_r <= 1'b0;
		end else if (pwr_cnt_r == 16'(PWRUP_CYC - 1)) begin
			pwr_ready_r <= 1'b1;
		end else begin
			pwr_cnt_r <= pwr_cnt_r + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// User outputs straight from flops
	assign card_selected_o = selected_r;
	assign power_ready_o = pwr_ready_r;
	assign prog_busy_o = state_r[4];
endmodule

//--- card_info_registers_spi_select_tb.sv
// Testbench: host end and card end joined, driven over Wishbone
`timescale 1ns/10ps
module card_info_registers_spi_select_tb;
	import card_pkg::*;
	// Identity values, arbitrary
	localparam logic [7:0] MAKER = 8'h3c;
	localparam logic [15:0] APP = 16'h7171;
	localparam logic [47:0] NAME = 48'h545354303031;
	localparam logic [7:0] REV = 8'h21;
	localparam logic [31:0] SER = 32'h00c0ffee;
	localparam logic [7:0] DATE = 8'h42;
	localparam logic [6:0] ID_CRC = 7'h2b;
	localparam logic [127:0] ID_EXP = {MAKER, APP, NAME, REV, SER, DATE,
		ID_CRC, 1'b1};
	// Record fixed part and user word; bit 0 of the word is forced to 1
	localparam logic [127:0] FIXED = 128'h0;
	localparam logic [15:0] USER_WORD = 16'habcc;
	localparam logic [127:0] REC_EXP = {FIXED[127:16], USER_WORD[15:1], 1'b1};
	// Long programming so a second frame lands inside it
	localparam int PROG_CYC = 2000;

	logic clk_i, rst_i, we, cyc, stb, ack, power_down;
	logic selected, prog_busy, power_ready;
	logic [7:0] adr, resp;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [127:0] rec;
	int bad_count, checked, n;

	//////////////////////////////////////////////////////////////////////
	// The two ends facing each other
	spi_link_if link();
	host_end #(.HALF(20)) i_host_end (.clk_i(clk_i), .rst_i(rst_i),
		.adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel),
		.cyc_i(cyc), .stb_i(stb), .ack_o(ack), .link(link));
	card_end #(.MAKER_CODE(MAKER), .APP_CODE(APP), .PRODUCT_NAME(NAME),
		.REVISION(REV), .SERIAL(SER), .MFG_DATE(DATE), .ID_CRC(ID_CRC),
		.SPEC_FIXED(FIXED), .PROG_CYC(PROG_CYC), .PWRUP_CYC(16)) i_card_end (
		.clk_i(clk_i), .rst_i(rst_i), .link(link), .power_down_i(power_down),
		.card_selected_o(selected), .prog_busy_o(prog_busy),
		.power_ready_o(power_ready));
	card_link_sva i_card_link_sva (.clk_i(clk_i), .rst_i(rst_i),
		.cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi),
		.miso(link.miso));

	//////////////////////////////////////////////////////////////////////
	// Clock, 4 ns period
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Compare and count
	task automatic check(input string what, input logic [127:0] seen,
		input logic [127:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One classic cycle: request held until ack is seen at a rising edge
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		adr <= a;
		we <= w;
		sel <= 4'hf;
		wdat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		@(posedge clk_i);
		while (ack !== 1'b1 && k < 1000) begin
			@(posedge clk_i);
			k++;
		end
		// A bus that never answers counts against the run
		if (ack !== 1'b1) begin
			bad_count++;
		end
		// Data taken at the same edge that sees ack, then release
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// Issue a link command and poll until the host end is idle again
	task automatic do_cmd(input logic [7:0] c, input logic [15:0] a);
		logic [31:0] s;
		int k;
		k = 0;
		wb(ADR_CMD, 1'b1, {8'h00, a, c}, s);
		s = 32'h00000001;
		while (s[ST_BUSY_BIT] !== 1'b0 && k < 20000) begin
			wb(ADR_STATUS, 1'b0, 32'h0, s);
			k++;
		end
		check("link idle", s[ST_BUSY_BIT], 1'b0);
		check("frame done", s[ST_DONE_BIT], 1'b1);
		resp = s[ST_RESP_LSB +: 8];
	endtask

	// Pull the 128-bit read-out, highest word first
	task automatic read_rec(output logic [127:0] r);
		logic [31:0] w;
		for (int i = 0; i < 4; i++) begin
			wb({ADR_RDATA_HI, i[1:0], 2'h0}, 1'b0, 32'h0, w);
			r = {r[95:0], w};
		end
	endtask

	// Wait for the power-up timer under a bound
	task automatic wait_ready;
		int k;
		k = 0;
		while (power_ready !== 1'b1 && k < 200) begin
			@(posedge clk_i);
			k++;
		end
		check("ready pin", power_ready, 1'b1);
	endtask

	// Closing report and verdict
	task stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////
	// Watchdog, well beyond the expected run of about 50k cycles
	initial begin
		repeat (90000) @(posedge clk_i);
		bad_count++;
		stop_test();
	end

	// Main sequence
	initial begin
		rst_i = 1'b1;
		power_down = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		we = 1'b0;
		sel = 4'hf;
		cyc = 1'b0;
		stb = 1'b0;
		bad_count = 0;
		checked = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		// Power-up held off: answer flags idle, status bit clear
		power_down <= 1'b1;
		do_cmd(CMD_READ_VOLT, 16'h0000);
		check("idle answer", resp, RESP_IDLE);
		check("ready pin low", power_ready, 1'b0);
		wb(8'h1c, 1'b0, 32'h0, q);
		check("busy status bit", q[31], 1'b0);
		power_down <= 1'b0;
		wait_ready();
		// Voltage word
		do_cmd(CMD_READ_VOLT, 16'h0000);
		check("voltage answer", resp, 8'h00);
		wb(8'h1c, 1'b0, 32'h0, q);
		check("voltage", q, VOLT_WINDOW | VOLT_READY);
		// Identity record
		do_cmd(CMD_READ_IDENT, 16'h0000);
		read_rec(rec);
		check("identity", rec, ID_EXP);
		// Addressing: default, standby, reassignment
		do_cmd(CMD_SELECT, ADDR_RESET);
		check("select default", selected, 1'b1);
		do_cmd(CMD_SELECT, ADDR_STANDBY);
		check("standby", selected, 1'b0);
		do_cmd(CMD_SET_ADDR, 16'h1234);
		do_cmd(CMD_SELECT, ADDR_RESET);
		check("old address", selected, 1'b0);
		do_cmd(CMD_SELECT, 16'h1234);
		check("new address", selected, 1'b1);
		// Broadcast and multi-block codes are refused
		for (int i = 0; i < 4; i++) begin
			do_cmd(i[1] ? (i[0] ? 8'h28 : 8'h02) : (i[0] ? 8'h19 : 8'h12),
				16'h0000);
			check("refused code", resp, RESP_ILLEGAL);
		end
		// Unmapped place reads zero, write ignored
		wb(8'h40, 1'b1, 32'hffffffff, q);
		wb(8'h40, 1'b0, 32'h0, q);
		check("unmapped", q, 32'h0);
		// Program the user part; host lets select go mid-programming
		wb(ADR_WDATA, 1'b1, {16'h0000, USER_WORD}, q);
		do_cmd(CMD_PROG_SPEC, 16'h0000);
		check("busy after release", prog_busy, 1'b1);
		check("select released", link.cs_n, 1'b1);
		do_cmd(CMD_READ_VOLT, 16'h0000);
		check("busy answer", resp, BUSY_BYTE);
		n = 0;
		while (prog_busy !== 1'b0 && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		check("programming ends", prog_busy, 1'b0);
		do_cmd(CMD_READ_SPEC, 16'h0000);
		read_rec(rec);
		check("user record", rec, REC_EXP);
		// Power cycle: address back to default, records kept
		power_down <= 1'b1;
		@(posedge clk_i);
		power_down <= 1'b0;
		@(posedge clk_i);
		check("deselect on power", selected, 1'b0);
		wait_ready();
		do_cmd(CMD_READ_SPEC, 16'h0000);
		read_rec(rec);
		check("record kept", rec, REC_EXP);
		do_cmd(CMD_READ_IDENT, 16'h0000);
		read_rec(rec);
		check("identity kept", rec, ID_EXP);
		do_cmd(CMD_SELECT, ADDR_RESET);
		check("address lost", selected, 1'b1);
		stop_test();
	end
endmodule

//--- card_link_sva.sv
// Protocol checker for the serial link between host end and card end
`timescale 1ns/10ps
module card_link_sva (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link wires
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso
);
	// Frame limits in link clock rises
	localparam int MIN_RISES = 32; // Command, two argument bytes, answer
	localparam int MAX_RISES = 160; // Command, two argument bytes, answer, one 16-byte record
	logic sclk_d_r; // Link clock one cycle ago
	logic [8:0] rise_cnt_r; // Link clock rises in this frame
	logic [8:0] rise_cnt_nxt;
	wire rise_w = sclk & ~sclk_d_r;
	// Count clears while deselected, so it always starts at select
	assign rise_cnt_nxt = cs_n ? 9'h000 : rise_cnt_r + {8'h00, rise_w};

	//////////////////////////////////////////////////////////////////////
	// Helper registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_d_r <= 1'b0;
			rise_cnt_r <= 9'h000;
		end else begin
			sclk_d_r <= sclk;
			rise_cnt_r <= rise_cnt_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Assertions, all in the one clock domain
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	idle_clock_a: assert property (cs_n |-> !sclk)
		else $error("link clock high while deselected");
	sel_setup_a: assert property ($fell(cs_n) |-> !sclk [*8])
		else $error("link clock rose too soon after select");
	sel_hold_a: assert property ($fell(cs_n) |=> !cs_n [*8])
		else $error("select dropped right after it was given");
	clk_half_a: assert property ($changed(sclk) |=> $stable(sclk) [*7])
		else $error("link clock half period too short");
	data_stable_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("host data moved while link clock high");
	byte_align_a: assert property ($rose(cs_n) |-> rise_cnt_r[2:0] == 3'h0)
		else $error("frame ended off a byte boundary");
	frame_min_a: assert property ($rose(cs_n) |-> rise_cnt_r >= MIN_RISES)
		else $error("frame shorter than command and answer");
	frame_max_a: assert property ($rose(cs_n) |-> rise_cnt_r <= MAX_RISES)
		else $error("frame longer than a single block");

	// Main frame kinds, and card driving data-out low while selected
	short_frame_c: cover property ($rose(cs_n) && rise_cnt_r == 9'h020);
	prog_frame_c: cover property ($rose(cs_n) && rise_cnt_r == 9'h030);
	record_frame_c: cover property ($rose(cs_n) && rise_cnt_r == 9'h0a0);
	card_low_c: cover property (!cs_n && !miso);
endmodule

//--- card_pkg.sv
// Shared constants for the serial card link, card register bank and host
package card_pkg;
	// Link framing
	localparam int BYTE_W = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [4:0] CMD_BYTES = 5'h03;
	localparam logic [4:0] RESP_IDX = 5'h03;
	localparam logic [4:0] VOLT_BYTES = 5'h04;
	localparam logic [4:0] REC_BYTES = 5'h10;
	localparam logic [4:0] PROG_BYTES = 5'h02;
	localparam logic [7:0] FILL_BYTE = 8'hff;
	localparam logic [7:0] BUSY_BYTE = 8'h00;
	// Command codes
	localparam logic [7:0] CMD_SET_ADDR = 8'h03;
	localparam logic [7:0] CMD_SELECT = 8'h07;
	localparam logic [7:0] CMD_READ_SPEC = 8'h09;
	localparam logic [7:0] CMD_READ_IDENT = 8'h0a;
	localparam logic [7:0] CMD_PROG_SPEC = 8'h1b;
	localparam logic [7:0] CMD_READ_VOLT = 8'h3a;
	// Response status bits
	localparam logic [7:0] RESP_IDLE = 8'h01;
	localparam logic [7:0] RESP_ILLEGAL = 8'h04;
	// Operating-voltage register layout
	localparam logic [31:0] VOLT_WINDOW = 32'h00ff8000;
	localparam logic [31:0] VOLT_READY = 32'h80000000;
	// Relative address values
	localparam logic [15:0] ADDR_RESET = 16'h0001;
	localparam logic [15:0] ADDR_STANDBY = 16'h0000;
	// User part of the card-specific record, bits 15:1
	localparam int SPEC_USER_W = 15;
	// Host register map (byte offsets)
	localparam logic [7:0] ADR_CMD = 8'h00;
	localparam logic [7:0] ADR_WDATA = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [3:0] ADR_RDATA_HI = 4'h1;
	// Host status bits
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_RESP_LSB = 8;
	// Cycle counts
	localparam int HALF_SCLK = 8;
	localparam int PROG_CYCLES = 64;
	localparam int PWRUP_CYCLES = 64;
	// Card link state
	typedef enum logic [4:0] {
		CS_CMD = 5'b00001,
		CS_RESP = 5'b00010,
		CS_OUT = 5'b00100,
		CS_IN = 5'b01000,
		CS_PROG = 5'b10000
	} card_state_t;
	// Host engine state
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_RUN = 3'b010,
		HS_END = 3'b100
	} host_state_t;
endpackage

//--- host_end.sv
// Host end: Wishbone-controlled serial link master for the card
`timescale 1ns/10ps
module host_end #(
	parameter int HALF = card_pkg::HALF_SCLK // Cycles per clock half
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	// Serial link
	spi_link_if.host link
);
	import card_pkg::*;

	host_state_t state_r; // Engine phase
	logic ack_r; // Bus answer
	logic [31:0] dat_r; // Read data
	logic [7:0] cmd_r; // Command code
	logic [15:0] arg_r; // Command argument
	logic [15:0] wdata_r; // Program data
	logic [7:0] resp_r; // Card answer byte
	logic [127:0] rdata_r; // Read-out data, last byte lowest
	logic done_r; // Transfer finished
	logic [15:0] div_r; // Clock divider
	logic sclk_r; // Link clock out
	logic cs_n_r; // Select out
	logic [7:0] txb_r; // Outgoing byte
	logic [7:0] rxb_r; // Incoming byte
	logic [2:0] bit_r; // Bit within byte
	logic [4:0] idx_r; // Byte index in transaction
	logic miso_m_r; // Data-in first stage
	logic miso_s_r; // Data-in second stage

	////////////////////////////////////////////////////////////////////
	// Bus decode
	wire bus_req = cyc_i & stb_i & ~ack_r;
	wire wr = bus_req & we_i;
	wire start = wr & (adr_i == ADR_CMD) & sel_i[0] &
		(state_r == HS_IDLE);
	wire [31:0] status = {16'h0000, resp_r, 6'h00, done_r,
		state_r != HS_IDLE};
	wire [31:0] rd_word = rdata_r[32*(3-adr_i[3:2]) +: 32];
	wire [31:0] rd_data = (adr_i == ADR_STATUS) ? status :
		(adr_i[7:4] == ADR_RDATA_HI) ? rd_word : 32'h00000000;

	// Bytes of data after the answer for each command
	wire is_prog = cmd_r == CMD_PROG_SPEC;
	wire [4:0] ndata = (cmd_r == CMD_READ_VOLT) ? VOLT_BYTES :
		(cmd_r == CMD_READ_IDENT || cmd_r == CMD_READ_SPEC) ?
		REC_BYTES : (is_prog ? PROG_BYTES : 5'h00);
	wire [4:0] last_idx = CMD_BYTES + ndata;
	wire refused = (resp_r & RESP_ILLEGAL) != 8'h00;
	wire [7:0] rx_byte = {rxb_r[6:0], miso_s_r};
	// Byte to send at each index
	wire [7:0] next_tx = (idx_r == 5'h01) ? arg_r[15:8] :
		(idx_r == 5'h02) ? arg_r[7:0] :
		(is_prog && idx_r == RESP_IDX + 5'h01) ? wdata_r[15:8] :
		(is_prog && idx_r == RESP_IDX + 5'h02) ? wdata_r[7:0] :
		FILL_BYTE;
	wire tick = div_r == 16'(HALF - 1);
	wire rise_t = tick & ~sclk_r & (state_r == HS_RUN);
	wire fall_t = tick & sclk_r & (state_r == HS_RUN);
	wire byte_end = rise_t & (bit_r == BIT_LAST);
	wire finish = fall_t & (bit_r == 3'h0) & ((idx_r > last_idx) |
		(idx_r == RESP_IDX + 5'h01 & refused));

	////////////////////////////////////////////////////////////////////
	// Bus answer, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end else begin
			ack_r <= bus_req;
			dat_r <= rd_data;
		end
	end
	assign ack_o = ack_r;
	assign dat_o = dat_r;

	// Order registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_r <= 8'h00;
			arg_r <= 16'h0000;
			wdata_r <= 16'h0000;
		end else begin
			if (start) begin
				cmd_r <= dat_i[7:0];
				arg_r <= dat_i[23:8];
			end
			if (wr & (adr_i == ADR_WDATA) & sel_i[0]) begin
				wdata_r[7:0] <= dat_i[7:0];
			end
			if (wr & (adr_i == ADR_WDATA) & sel_i[1]) begin
				wdata_r[15:8] <= dat_i[15:8];
			end
		end
	end

	// Data-in synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			miso_m_r <= 1'b1;
			miso_s_r <= 1'b1;
		end else begin
			miso_m_r <= link.miso;
			miso_s_r <= miso_m_r;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Divider: the host makes the link clock
	always_ff @(posedge clk_i) begin
		if (rst_i | tick | (state_r == HS_IDLE)) begin
			div_r <= 16'h0000;
		end else begin
			div_r <= div_r + 16'h0001;
		end
	end

	// Engine: select held low from first to last byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= HS_IDLE;
			cs_n_r <= 1'b1;
			sclk_r <= 1'b0;
			txb_r <= FILL_BYTE;
			done_r <= 1'b0;
		end else if (start) begin
			state_r <= HS_RUN;
			cs_n_r <= 1'b0;
			txb_r <= dat_i[7:0];
			done_r <= 1'b0;
		end else if (rise_t) begin
			sclk_r <= 1'b1;
		end else if (finish) begin
			sclk_r <= 1'b0;
			state_r <= HS_END;
		end else if (fall_t) begin
			sclk_r <= 1'b0;
			txb_r <= bit_r == 3'h0 ? next_tx : {txb_r[6:0], 1'b1};
		end else if (tick & (state_r == HS_END)) begin
			// Release also while the card still programs
			state_r <= HS_IDLE;
			cs_n_r <= 1'b1;
			done_r <= 1'b1;
		end
	end

	// Byte counting and capture, aligned to select
	always_ff @(posedge clk_i) begin
		if (rst_i | start) begin
			bit_r <= 3'h0;
			idx_r <= 5'h00;
			rxb_r <= 8'h00;
			resp_r <= 8'h00;
			rdata_r <= '0;
		end else if (rise_t) begin
			bit_r <= bit_r + 3'h1;
			rxb_r <= rx_byte;
			if (byte_end) begin
				idx_r <= idx_r + 5'h01;
				if (idx_r == RESP_IDX) begin
					resp_r <= rx_byte;
				end else if (idx_r > RESP_IDX & ~is_prog) begin
					rdata_r <= {rdata_r[119:0], rx_byte};
				end
			end
		end
	end

	assign link.cs_n = cs_n_r;
	assign link.sclk = sclk_r;
	assign link.mosi = txb_r[7];
endmodule

//--- link_sync.sv
// Two-flop synchroniser for a group of link pins
`timescale 1ns/10ps
module link_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pins in, synchronised copy out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r; // First stage, read only by second
	logic [W-1:0] sync_r; // Second stage, safe to use

	// Both stages step every edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end
	assign q_o = sync_r;
endmodule

//--- spi_link_if.sv
// Four-wire serial link between host controller and card
`timescale 1ns/10ps
interface spi_link_if;
	logic cs_n; // Select, active low
	logic sclk; // Link clock from host
	logic mosi; // Host to card data
	logic miso; // Card to host data
	modport host (output cs_n, output sclk, output mosi, input miso);
	modport card (input cs_n, input sclk, input mosi, output miso);
endinterface
